// File: logic/op_sample_pkg.sv
// Constants for the op sample capture registers
package op_sample_pkg;
    // ********************************
    // Register addresses
    // ********************************
    localparam logic [31:0] ADDR_BR_STATUS = 32'h0000_0100;
    localparam logic [31:0] ADDR_DC_STATUS = 32'h0000_0101;
    localparam logic [31:0] ADDR_LIN_ADDR  = 32'h0000_0102;
    localparam logic [31:0] ADDR_PHYS_ADDR = 32'h0000_0103;
    localparam logic [31:0] ADDR_BR_TARGET = 32'h0000_0104;
    // ********************************
    // Branch status fields
    // ********************************
    localparam int BIT_RIP_INVALID = 38;
    localparam int BIT_BR_RETIRED  = 37;
    localparam int BIT_BR_MISPRED  = 36;
    localparam int BIT_BR_TAKEN    = 35;
    localparam int BIT_BR_RETURN   = 34;
    // ********************************
    // Data cache status fields
    // ********************************
    localparam int LAT_LSB         = 32;
    localparam int LAT_W           = 16;
    localparam int BIT_PHYS_VALID  = 18;
    localparam int BIT_LIN_VALID   = 17;
    localparam int BIT_LOCKED      = 15;
    localparam int BIT_UNCACHEABLE = 14;
    localparam int BIT_WCOMBINE    = 13;
    localparam int BIT_MISALIGN    = 8;
    localparam int BIT_DC_MISS     = 7;
    localparam int BIT_TLB_1G      = 5;
    localparam int BIT_TLB_2M      = 4;
    localparam int BIT_TLB_MISS    = 2;
    localparam int BIT_STORE       = 1;
    localparam int BIT_LOAD        = 0;
    // ********************************
    // Widths and writable masks
    // ********************************
    localparam int VA_BITS = 48;
    localparam int PA_BITS = 52;
    localparam logic [63:0] MASK_BR_STATUS = 64'h0000_007C_0000_0000;
    localparam logic [63:0] MASK_DC_STATUS = 64'h0000_FFFF_0006_E1B7;
    localparam logic [63:0] MASK_PHYS      = 64'h000F_FFFF_FFFF_FFFF;
    localparam logic [63:0] ZERO64         = 64'h0000_0000_0000_0000;
    localparam logic [15:0] LAT_ONE        = 16'h0001;
    localparam logic [15:0] LAT_MAX        = 16'hFFFF;
endpackage : op_sample_pkg

// File: logic/op_sample_capture_regs.sv
// Capture registers for one tagged, sampled op
//
// Behaviour
// R01: Set op address invalid when address unusable
// R02: Set branch retired on retired branch
// R03: Set mispredicted on retired mispredicted branch
// R04: Set taken on retired taken branch
// R05: Set return flag on retired return
// R06: Cache status only from lower 128-bit portion
// R07: Latency counts cycles miss to data
// R08: Store latency value is not meaningful
// R09: Set physical valid when physical address valid
// R10: Set linear valid when linear address valid
// R11: Set locked flag for locked access
// R12: Set uncacheable flag for uncacheable access
// R13: Set write-combining flag for such access
// R14: Set misalign flag on misalignment penalty
// R15: Set cache miss flag on data miss
// R16: Set 1G or 2M TLB hit flags
// R17: Set TLB miss flag on L1 miss
// R18: Set store and load flags
// R19: Store canonical operand linear address
// R20: Store 52-bit physical address, upper zero
// R21: Store canonical branch target address
// R22: Not-taken conditional gives fall-through address
// R23: Capture all on retire, then set valid
// R24: Op address held canonical, valid with flags; only the address-invalid flag is kept, there is no op address register
// R25: Software reaches registers by MSR instructions
// R26: Reserved bits zero, writes store value
`timescale 1ns/1ps
module op_sample_capture_regs (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        tag_start,
    input  wire logic        retire_valid,
    input  wire logic        rip_valid,
    input  wire logic        br_retired,
    input  wire logic        br_mispred,
    input  wire logic        br_taken,
    input  wire logic        br_cond,
    input  wire logic        br_return,
    input  wire logic [63:0] br_target,
    input  wire logic [63:0] br_fall_through,
    input  wire logic        lsu_valid,
    input  wire logic        lsu_upper,
    input  wire logic        lsu_load,
    input  wire logic        lsu_store,
    input  wire logic        lsu_locked,
    input  wire logic        lsu_uc,
    input  wire logic        lsu_wc,
    input  wire logic        lsu_misalign,
    input  wire logic        lsu_dc_miss,
    input  wire logic        lsu_tlb_1g,
    input  wire logic        lsu_tlb_2m,
    input  wire logic        lsu_tlb_miss,
    input  wire logic        lsu_lin_valid,
    input  wire logic        lsu_phys_valid,
    input  wire logic [63:0] lsu_lin_addr,
    input  wire logic [51:0] lsu_phys_addr,
    input  wire logic        miss_detect,
    input  wire logic        miss_data_back,
    input  wire logic        sample_valid_clear,
    input  wire logic        msr_rd,
    input  wire logic        msr_wr,
    input  wire logic [31:0] msr_addr,
    input  wire logic [63:0] msr_wdata,
    output logic      [63:0] msr_rdata_ff,
    output logic             msr_ack_ff,
    output logic             msr_err_ff,
    output logic             op_sample_valid_ff
);
    // ********************************
    // Functions
    // ********************************
    // Sign-extend from the implemented virtual address width
    function automatic logic [63:0] canon(input logic [63:0] a);
        logic [63:0] r;
        r = a;
        for (int i = op_sample_pkg::VA_BITS; i < 64; i++) begin
            r[i] = a[op_sample_pkg::VA_BITS-1];
        end
        return r;
    endfunction : canon

    function automatic logic [2:0] reg_sel(input logic [31:0] a);
        logic [2:0] s;
        s = 3'h0;
        if (a == op_sample_pkg::ADDR_BR_STATUS) begin
            s = 3'h1;
        end else if (a == op_sample_pkg::ADDR_DC_STATUS) begin
            s = 3'h2;
        end else if (a == op_sample_pkg::ADDR_LIN_ADDR) begin
            s = 3'h3;
        end else if (a == op_sample_pkg::ADDR_PHYS_ADDR) begin
            s = 3'h4;
        end else if (a == op_sample_pkg::ADDR_BR_TARGET) begin
            s = 3'h5;
        end
        return s;
    endfunction : reg_sel

    // ********************************
    // Working state while the op is in flight
    // ********************************
    logic [63:0] cache_w_ff;
    logic [63:0] lin_w_ff;
    logic [51:0] phys_w_ff;
    logic [15:0] lat_ff;
    logic        lat_run_ff;
    logic [63:0] nxt_cache_w;
    logic        lsu_take;
    logic [2:0]  sel;

    // Upper half of a split access is ignored
    assign lsu_take = lsu_valid && !lsu_upper; // R06
    assign sel      = reg_sel(msr_addr);

    always_comb begin
        nxt_cache_w = op_sample_pkg::ZERO64;
        nxt_cache_w[op_sample_pkg::BIT_PHYS_VALID]  = lsu_phys_valid; // R09
        nxt_cache_w[op_sample_pkg::BIT_LIN_VALID]   = lsu_lin_valid; // R10
        nxt_cache_w[op_sample_pkg::BIT_LOCKED]      = lsu_locked; // R11
        nxt_cache_w[op_sample_pkg::BIT_UNCACHEABLE] = lsu_uc; // R12
        nxt_cache_w[op_sample_pkg::BIT_WCOMBINE]    = lsu_wc; // R13
        nxt_cache_w[op_sample_pkg::BIT_MISALIGN]    = lsu_misalign; // R14
        nxt_cache_w[op_sample_pkg::BIT_DC_MISS]     = lsu_dc_miss; // R15
        nxt_cache_w[op_sample_pkg::BIT_TLB_1G]      = lsu_tlb_1g; // R16
        nxt_cache_w[op_sample_pkg::BIT_TLB_2M]      = lsu_tlb_2m; // R16
        nxt_cache_w[op_sample_pkg::BIT_TLB_MISS]    = lsu_tlb_miss; // R17
        nxt_cache_w[op_sample_pkg::BIT_STORE]       = lsu_store; // R18
        nxt_cache_w[op_sample_pkg::BIT_LOAD]        = lsu_load; // R18
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cache_w_ff <= op_sample_pkg::ZERO64;
            lin_w_ff   <= op_sample_pkg::ZERO64;
            phys_w_ff  <= op_sample_pkg::ZERO64[51:0];
        end else if (tag_start) begin
            cache_w_ff <= op_sample_pkg::ZERO64;
            lin_w_ff   <= op_sample_pkg::ZERO64;
            phys_w_ff  <= op_sample_pkg::ZERO64[51:0];
        end else if (lsu_take) begin
            cache_w_ff <= nxt_cache_w; // R06
            lin_w_ff   <= canon(lsu_lin_addr); // R19
            phys_w_ff  <= lsu_phys_addr; // R20
        end
    end

    // Saturates rather than wraps; stores still count, value unused
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lat_ff     <= op_sample_pkg::ZERO64[15:0];
            lat_run_ff <= 1'b0;
        end else if (tag_start) begin
            lat_ff     <= op_sample_pkg::ZERO64[15:0];
            lat_run_ff <= 1'b0;
        end else if (miss_detect && !lat_run_ff) begin
            lat_ff     <= op_sample_pkg::ZERO64[15:0]; // R07
            lat_run_ff <= 1'b1;
        end else if (lat_run_ff) begin
            if (lat_ff != op_sample_pkg::LAT_MAX) begin
                lat_ff <= lat_ff + op_sample_pkg::LAT_ONE; // R07 R08
            end
            if (miss_data_back) begin
                lat_run_ff <= 1'b0;
            end
        end
    end

    // ********************************
    // Capture registers
    // ********************************
    logic [63:0] br_stat_ff;
    logic [63:0] cache_ff;
    logic [63:0] lin_ff;
    logic [63:0] phys_ff;
    logic [63:0] tgt_ff;
    logic [63:0] nxt_br_stat;
    logic [63:0] nxt_cache;

    always_comb begin
        nxt_br_stat = op_sample_pkg::ZERO64;
        nxt_br_stat[op_sample_pkg::BIT_RIP_INVALID] = !rip_valid; // R01 R24
        nxt_br_stat[op_sample_pkg::BIT_BR_RETIRED] = br_retired; // R02
        nxt_br_stat[op_sample_pkg::BIT_BR_MISPRED] =
            br_retired && br_mispred; // R03
        nxt_br_stat[op_sample_pkg::BIT_BR_TAKEN] =
            br_retired && br_taken; // R04
        nxt_br_stat[op_sample_pkg::BIT_BR_RETURN] =
            br_retired && br_return; // R05
        nxt_cache = cache_w_ff;
        nxt_cache[op_sample_pkg::LAT_LSB +: op_sample_pkg::LAT_W] =
            lat_ff; // R07
    end

    // Retire capture outranks a software write in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            br_stat_ff <= op_sample_pkg::ZERO64;
            cache_ff   <= op_sample_pkg::ZERO64;
            lin_ff     <= op_sample_pkg::ZERO64;
            phys_ff    <= op_sample_pkg::ZERO64;
            tgt_ff     <= op_sample_pkg::ZERO64;
        end else if (retire_valid) begin
            br_stat_ff <= nxt_br_stat; // R23
            cache_ff   <= nxt_cache; // R23
            lin_ff     <= lin_w_ff; // R19
            phys_ff    <= {12'h000, phys_w_ff}; // R20
            if (br_cond && !br_taken) begin
                tgt_ff <= canon(br_fall_through); // R22
            end else begin
                tgt_ff <= canon(br_target); // R21
            end
        end else if (msr_wr) begin
            if (sel == 3'h1) begin
                br_stat_ff <= msr_wdata & op_sample_pkg::MASK_BR_STATUS; // R26
            end else if (sel == 3'h2) begin
                cache_ff <= msr_wdata & op_sample_pkg::MASK_DC_STATUS; // R26
            end else if (sel == 3'h3) begin
                lin_ff <= msr_wdata; // R26
            end else if (sel == 3'h4) begin
                phys_ff <= msr_wdata & op_sample_pkg::MASK_PHYS; // R20 R26
            end else if (sel == 3'h5) begin
                tgt_ff <= msr_wdata; // R26
            end
        end
    end

    // Valid follows the capture edge; a set beats a clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            op_sample_valid_ff <= 1'b0;
        end else if (retire_valid) begin
            op_sample_valid_ff <= 1'b1; // R23
        end else if (sample_valid_clear) begin
            op_sample_valid_ff <= 1'b0;
        end
    end

    // ********************************
    // MSR access port
    // ********************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            msr_rdata_ff <= op_sample_pkg::ZERO64;
            msr_ack_ff   <= 1'b0;
            msr_err_ff   <= 1'b0;
        end else begin
            msr_ack_ff <= msr_rd || msr_wr; // R25
            msr_err_ff <= (msr_rd || msr_wr) && (sel == 3'h0);
            if (!msr_rd) begin
                msr_rdata_ff <= op_sample_pkg::ZERO64;
            end else if (sel == 3'h1) begin
                msr_rdata_ff <= br_stat_ff;
            end else if (sel == 3'h2) begin
                msr_rdata_ff <= cache_ff;
            end else if (sel == 3'h3) begin
                msr_rdata_ff <= lin_ff;
            end else if (sel == 3'h4) begin
                msr_rdata_ff <= phys_ff;
            end else if (sel == 3'h5) begin
                msr_rdata_ff <= tgt_ff;
            end else begin
                msr_rdata_ff <= op_sample_pkg::ZERO64; // R26
            end
        end
    end

    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_miss_open;
        miss_detect && !lat_run_ff && !tag_start;
    endsequence
    sequence s_miss_wait;
        (!miss_data_back && !tag_start) [*2];
    endsequence

    property p_rip_inv;
        retire_valid |=>
            br_stat_ff[op_sample_pkg::BIT_RIP_INVALID] == !$past(rip_valid);
    endproperty
    a_rip_inv: assert property (p_rip_inv) else $error("rip invalid"); // R01

    property p_br_ret;
        retire_valid && br_retired |=>
            br_stat_ff[op_sample_pkg::BIT_BR_RETIRED];
    endproperty
    a_br_ret: assert property (p_br_ret) else $error("branch retired"); // R02

    property p_br_misp;
        retire_valid |=> br_stat_ff[op_sample_pkg::BIT_BR_MISPRED] ==
            ($past(br_retired) && $past(br_mispred));
    endproperty
    a_br_misp: assert property (p_br_misp) else $error("mispredict"); // R03

    property p_br_tkn;
        retire_valid && br_retired && !br_taken |=>
            !br_stat_ff[op_sample_pkg::BIT_BR_TAKEN];
    endproperty
    a_br_tkn: assert property (p_br_tkn) else $error("taken"); // R04

    property p_upper;
        lsu_valid && lsu_upper && !tag_start |=> $stable(cache_w_ff);
    endproperty
    a_upper: assert property (p_upper) else $error("upper half taken"); // R06

    property p_lat;
        s_miss_open ##1 s_miss_wait |=> lat_ff == 16'h0002;
    endproperty
    a_lat: assert property (p_lat) else $error("miss latency"); // R07

    property p_phys_rsvd;
        phys_ff[63:op_sample_pkg::PA_BITS] == 12'h000;
    endproperty
    a_phys_rsvd: assert property (p_phys_rsvd) else $error("phys rsvd"); // R20

    property p_fall;
        retire_valid && br_cond && !br_taken |=>
            tgt_ff == canon($past(br_fall_through));
    endproperty
    a_fall: assert property (p_fall) else $error("fall through"); // R22

    property p_valid;
        retire_valid |=> op_sample_valid_ff && cache_ff == $past(nxt_cache);
    endproperty
    a_valid: assert property (p_valid) else $error("sample valid"); // R23

    property p_rtn;
        retire_valid |=> br_stat_ff[op_sample_pkg::BIT_BR_RETURN] ==
            ($past(br_retired) && $past(br_return));
    endproperty
    a_rtn: assert property (p_rtn) else $error("return flag"); // R05

    property p_ldst;
        lsu_take && !tag_start |=>
            cache_w_ff[op_sample_pkg::BIT_LOAD] == $past(lsu_load) &&
            cache_w_ff[op_sample_pkg::BIT_STORE] == $past(lsu_store);
    endproperty
    a_ldst: assert property (p_ldst) else $error("load store flags"); // R18

    property p_tlb;
        lsu_take && !tag_start |=>
            cache_w_ff[op_sample_pkg::BIT_TLB_MISS] == $past(lsu_tlb_miss) &&
            cache_w_ff[op_sample_pkg::BIT_TLB_2M] == $past(lsu_tlb_2m) &&
            cache_w_ff[op_sample_pkg::BIT_TLB_1G] == $past(lsu_tlb_1g);
    endproperty
    a_tlb: assert property (p_tlb) else $error("tlb flags"); // R16 R17

    property p_dc_miss;
        lsu_take && !tag_start |=>
            cache_w_ff[op_sample_pkg::BIT_DC_MISS] == $past(lsu_dc_miss) &&
            cache_w_ff[op_sample_pkg::BIT_MISALIGN] == $past(lsu_misalign);
    endproperty
    a_dc_miss: assert property (p_dc_miss) else $error("dc miss"); // R14 R15

    property p_kind;
        lsu_take && !tag_start |=>
            cache_w_ff[op_sample_pkg::BIT_LOCKED] == $past(lsu_locked) &&
            cache_w_ff[op_sample_pkg::BIT_UNCACHEABLE] == $past(lsu_uc) &&
            cache_w_ff[op_sample_pkg::BIT_WCOMBINE] == $past(lsu_wc);
    endproperty
    a_kind: assert property (p_kind) else $error("kind"); // R11 R12 R13

    property p_av;
        lsu_take && !tag_start |=>
            cache_w_ff[op_sample_pkg::BIT_LIN_VALID] == $past(lsu_lin_valid)
            && cache_w_ff[op_sample_pkg::BIT_PHYS_VALID] ==
                $past(lsu_phys_valid);
    endproperty
    a_av: assert property (p_av) else $error("addr valid"); // R09 R10

    property p_lin;
        lsu_take && !tag_start |=> lin_w_ff == canon($past(lsu_lin_addr));
    endproperty
    a_lin: assert property (p_lin) else $error("linear address"); // R19

    property p_phys;
        lsu_take && !tag_start |=> phys_w_ff == $past(lsu_phys_addr);
    endproperty
    a_phys: assert property (p_phys) else $error("physical address"); // R20

    property p_tgt;
        retire_valid && !(br_cond && !br_taken) |=>
            tgt_ff == canon($past(br_target));
    endproperty
    a_tgt: assert property (p_tgt) else $error("branch target"); // R21
endmodule : op_sample_capture_regs

// File: verification/pipe_model.sv
// Pipeline side model: tags, executes and retires one op at a time
`timescale 1ns/1ps
module pipe_model (
    input  wire logic        clk,
    output logic             tag_start,
    output logic             retire_valid,
    output logic       [5:0] br,
    output logic      [63:0] tgt,
    output logic      [63:0] fall,
    output logic             lsu_valid,
    output logic             lsu_upper,
    output logic      [11:0] ls,
    output logic      [63:0] lin,
    output logic      [51:0] phys,
    output logic             miss_detect,
    output logic             miss_data_back
);
    initial begin
        {tag_start, retire_valid, lsu_valid, lsu_upper} = 4'h0;
        {miss_detect, miss_data_back} = 2'h0;
        {br, ls, tgt, fall, lin, phys} = '0;
    end
    // Tag, lower strobe, upper strobe, optional miss, retire
    task automatic run_op(input logic [5:0] b, input logic [11:0] l,
                          input int lat, input logic [63:0] t, f, a,
                          input logic [51:0] p);
        @(negedge clk) tag_start = 1'b1;
        @(negedge clk) tag_start = 1'b0;
        {lsu_valid, ls, lin, phys} = {1'b1, l, a, p};
        // Upper half carries inverted status, must never be captured
        @(negedge clk) {lsu_upper, ls, lin, phys} = {1'b1, ~l, ~a, ~p};
        @(negedge clk) {lsu_valid, lsu_upper} = 2'h0;
        if (lat > 0) begin
            miss_detect = 1'b1;
            @(negedge clk) miss_detect = 1'b0;
            repeat (lat - 1) @(negedge clk);
            miss_data_back = 1'b1;
            @(negedge clk) miss_data_back = 1'b0;
        end
        {retire_valid, br, tgt, fall} = {1'b1, b, t, f};
        // Released lines show junk, not the last value
        @(negedge clk) {retire_valid, br, tgt, fall} = {1'b0, ~b, ~t, ~f};
    endtask : run_op
endmodule : pipe_model

// File: verification/op_sample_capture_regs_tb_top.sv
// Self-checking bench for the op sample capture registers
`timescale 1ns/1ps
module op_sample_capture_regs_tb_top;
    typedef struct {
        logic [5:0]  b;
        logic [11:0] l;
        int          lat;
        logic [63:0] t;
        logic [63:0] f;
        logic [63:0] a;
        logic [51:0] p;
    } op_row_t;
    logic        clk, rst, sample_valid_clear, msr_rd, msr_wr;
    logic [31:0] msr_addr;
    logic [63:0] msr_wdata, msr_rdata_ff, tgt, fall, lin, v;
    logic        msr_ack_ff, msr_err_ff, op_sample_valid_ff, e;
    logic        tag_start, retire_valid, lsu_valid, lsu_upper;
    logic        miss_detect, miss_data_back;
    logic [5:0]  br;
    logic [11:0] ls;
    logic [51:0] phys;
    int          bad_count, checks_done;
    op_row_t     rows [4];
    op_row_t     r;
    logic [63:0] ex [5];

    op_sample_capture_regs i_dut (
        .clk(clk), .rst(rst), .tag_start(tag_start),
        .retire_valid(retire_valid), .rip_valid(br[5]),
        .br_retired(br[4]), .br_mispred(br[3]), .br_taken(br[2]),
        .br_cond(br[1]), .br_return(br[0]), .br_target(tgt),
        .br_fall_through(fall), .lsu_valid(lsu_valid),
        .lsu_upper(lsu_upper), .lsu_load(ls[11]), .lsu_store(ls[10]),
        .lsu_locked(ls[9]), .lsu_uc(ls[8]), .lsu_wc(ls[7]),
        .lsu_misalign(ls[6]), .lsu_dc_miss(ls[5]), .lsu_tlb_1g(ls[4]),
        .lsu_tlb_2m(ls[3]), .lsu_tlb_miss(ls[2]),
        .lsu_lin_valid(ls[1]), .lsu_phys_valid(ls[0]),
        .lsu_lin_addr(lin), .lsu_phys_addr(phys),
        .miss_detect(miss_detect), .miss_data_back(miss_data_back),
        .sample_valid_clear(sample_valid_clear), .msr_rd(msr_rd),
        .msr_wr(msr_wr), .msr_addr(msr_addr), .msr_wdata(msr_wdata),
        .msr_rdata_ff(msr_rdata_ff), .msr_ack_ff(msr_ack_ff),
        .msr_err_ff(msr_err_ff), .op_sample_valid_ff(op_sample_valid_ff)
    );
    pipe_model i_pipe (
        .clk(clk), .tag_start(tag_start), .retire_valid(retire_valid),
        .br(br), .tgt(tgt), .fall(fall), .lsu_valid(lsu_valid),
        .lsu_upper(lsu_upper), .ls(ls), .lin(lin), .phys(phys),
        .miss_detect(miss_detect), .miss_data_back(miss_data_back)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    function automatic logic [63:0] canon(input logic [63:0] x);
        return {{16{x[47]}}, x[47:0]};
    endfunction : canon

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [63:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Pulse request for one cycle, then wait a bounded time for ack
    task automatic msr(input logic wr, input logic [31:0] ad,
                       input logic [63:0] wd, output logic [63:0] rd,
                       output logic er);
        int i;
        @(negedge clk) {msr_rd, msr_wr} = {~wr, wr};
        {msr_addr, msr_wdata} = {ad, wd};
        @(negedge clk) {msr_rd, msr_wr} = 2'h0;
        for (i = 0; i < 4 && msr_ack_ff !== 1'b1; i++) @(negedge clk);
        if (i == 4) begin
            bad_count++;
            report_and_stop();
        end
        rd = msr_rdata_ff;
        er = msr_err_ff;
    endtask : msr

    task automatic read_all(input string what);
        for (int k = 0; k < 5; k++) begin
            msr(1'b0, op_sample_pkg::ADDR_BR_STATUS + 32'(k), 64'h0, v, e);
            check(what, v, ex[k]);
            check("read error", {63'h0, e}, 64'h0);
        end
    endtask : read_all

    // ********************************
    // Stimulus table
    // ********************************
    initial begin
        {rst, sample_valid_clear, msr_rd, msr_wr} = 4'h8;
        msr_addr = 32'h0;
        msr_wdata = 64'h0;
        bad_count = 0;
        checks_done = 0;
        rows[0] = '{6'h34, 12'h807, 4, 64'hFFFF_8000_0000_1230,
                    64'h0000_0000_0040_1000, 64'hFFFF_FFFF_FFFF_FFF0,
                    52'h0_0012_3456_7890};
        rows[1] = '{6'h1A, 12'h7D0, 1, 64'h0000_0000_0040_2000,
                    64'h0000_0000_0040_1006, 64'h0000_7FFF_FFFF_FFF8,
                    52'hF_FFFF_FFFF_FFFF};
        rows[2] = '{6'h35, 12'h828, 0, 64'h0000_8000_0000_0100,
                    64'h0000_0000_0000_0200, 64'h0000_8000_0000_0040,
                    52'h0_0000_0000_1000};
        // Not retired: branch outcome inputs must not show
        rows[3] = '{6'h2D, 12'h000, 0, 64'h0000_0000_0000_0300,
                    64'h0000_0000_0000_0400, 64'h0000_0000_0000_0000,
                    52'h0_0000_0000_0000};
        repeat (3) @(negedge clk);
        rst = 1'b0;
        check("valid after reset", {63'h0, op_sample_valid_ff}, 64'h0);
        ex = '{default: 64'h0};
        read_all("reset value");
        foreach (rows[n]) begin
            r = rows[n];
            i_pipe.run_op(r.b, r.l, r.lat, r.t, r.f, r.a, r.p);
            @(negedge clk);
            check("sample valid", {63'h0, op_sample_valid_ff}, 64'h1);
            ex[0] = {25'h0, ~r.b[5], r.b[4], r.b[3] & r.b[4],
                     r.b[2] & r.b[4], r.b[0] & r.b[4], 34'h0};
            ex[1] = {16'h0, 16'(r.lat), 13'h0, r.l[0], r.l[1], 1'b0,
                     r.l[9:7], 4'h0, r.l[6:5], 1'b0,
                     r.l[4:3], 1'b0, r.l[2], r.l[10], r.l[11]};
            ex[2] = canon(r.a);
            ex[3] = {12'h0, r.p};
            ex[4] = (r.b[1] && !r.b[2]) ? canon(r.f) : canon(r.t);
            read_all("captured");
            sample_valid_clear = 1'b1;
            @(negedge clk) sample_valid_clear = 1'b0;
            @(negedge clk);
            check("valid cleared", {63'h0, op_sample_valid_ff}, 64'h0);
        end
        // Retire and clear on one edge: the set must win
        sample_valid_clear = 1'b1;
        i_pipe.run_op(r.b, r.l, r.lat, r.t, r.f, r.a, r.p);
        check("set beats clear", {63'h0, op_sample_valid_ff}, 64'h1);
        sample_valid_clear = 1'b0;
        // ********************************
        // Masked writes and unmapped access
        // ********************************
        ex = '{op_sample_pkg::MASK_BR_STATUS, op_sample_pkg::MASK_DC_STATUS,
               64'hFFFF_FFFF_FFFF_FFFF, op_sample_pkg::MASK_PHYS,
               64'hFFFF_FFFF_FFFF_FFFF};
        for (int k = 0; k < 5; k++) begin
            msr(1'b1, op_sample_pkg::ADDR_BR_STATUS + 32'(k),
                64'hFFFF_FFFF_FFFF_FFFF, v, e);
        end
        read_all("written value");
        msr(1'b1, 32'h0000_0105, 64'hFFFF_FFFF_FFFF_FFFF, v, e);
        check("unmapped write error", {63'h0, e}, 64'h1);
        msr(1'b0, 32'h0000_0105, 64'h0, v, e);
        check("unmapped read data", v, 64'h0);
        check("unmapped read error", {63'h0, e}, 64'h1);
        // ********************************
        // Reset in mid-run clears every register
        // ********************************
        @(negedge clk) rst = 1'b1;
        @(negedge clk) rst = 1'b0;
        check("valid after reset", {63'h0, op_sample_valid_ff}, 64'h0);
        ex = '{default: 64'h0};
        read_all("mid-run reset");
        report_and_stop();
    end
endmodule : op_sample_capture_regs_tb_top
